// [shared/msamc_consts.svh]
// Summary of operation
// - Every CPU access arrives virtual and leaves as a physical address, translated in user mode only.
// - ROM, RAM, EEPROM each have two partitions; only test mode reaches both.
// - Segments are written in system mode and checked only in user mode.
// - A segment entry holds rights, start, end, offset and register group rights.
// - Up to 64 segments; an invalid entry ends the table early.
// - A relocated address may never reach the reserved partition.
// - Forbidden user accesses and accesses outside real memory raise an exception.
// - Sixteen group rights go to the register checker; user mode uses segment's.
// - Boot, test and system mode grant all sixteen groups fully.
// - Vendor mode uses two group registers which cannot be written there.
// - Refused register writes change nothing; refused reads give a constant.
// - Banked register has user, system and super-system copies chosen by mode.
// - Rights of the block's other registers are fixed per function and mode.
// - Two flags: super set is boot/test/vendor, system set is system, else user.
// - System call vector sets system flag from user mode; elsewhere an exception.
// - Configuration vector enters vendor mode (test mode if the selector holds test), except in contact-only builds.
// - Every exception entry sets the system flag.
// - A system-mode option chooses whether interrupts run in user or system mode.
// - Return restores both flags; in user mode needs user interrupts and one active.
// - Call to 0x800000 in system mode enters user mode without pushing a return.
// - Software writes to the mode flags can only clear them.
// - Exceptions cannot be masked, vector by source and enter system mode.
// - Reset starts in boot mode with the super flag set.
`ifndef MSAMC_CONSTS_SVH
`define MSAMC_CONSTS_SVH
`define MSAMC_REG_MODE 6'h00
`define MSAMC_REG_CTRL 6'h04
`define MSAMC_REG_VRD 6'h08
`define MSAMC_REG_VWR 6'h0c
`define MSAMC_REG_SIDX 6'h10
`define MSAMC_REG_SSTART 6'h14
`define MSAMC_REG_SEND 6'h18
`define MSAMC_REG_SOFS 6'h1c
`define MSAMC_REG_SGRP 6'h20
`define MSAMC_REG_SATTR 6'h24
`define MSAMC_REG_BANK 6'h28
`define MSAMC_REG_FAULT 6'h2c
`define MSAMC_BIT_SYS 0
`define MSAMC_BIT_SUPER 1
`define MSAMC_FIXED_RD 32'hdead_0000
`define MSAMC_ROM_BASE 24'h000000
`define MSAMC_ROM_SIZE 24'h040000
`define MSAMC_RAM_BASE 24'h100000
`define MSAMC_RAM_SIZE 24'h002000
`define MSAMC_EE_BASE 24'h200000
`define MSAMC_EE_SIZE 24'h040000
`define MSAMC_SCALL_BASE 24'h00ff00
`define MSAMC_CCALL_BASE 24'h00fe00
`define MSAMC_VEC_SPAN 24'h000100
`define MSAMC_USER_ENTRY 24'h800000
`define MSAMC_VEC_EXT 24'h000008
`define MSAMC_VEC_RET 24'h000010
`define MSAMC_VEC_CALL 24'h000018
`define MSAMC_VEC_ACCESS 24'h000020
`endif

// [shared/msamc_pkg.sv]
package msamc_pkg;
   typedef enum logic [2:0] {MODE_BOOT, MODE_TEST, MODE_VENDOR, MODE_SYSTEM, MODE_USER} msamc_mode_e;
   typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_FETCH} msamc_kind_e;
   typedef struct packed {
      logic valid;
      logic [23:0] addr;
      msamc_kind_e kind;
   } msamc_acc_s;
   typedef struct packed {
      logic call;
      logic [23:0] target;
      logic ret;
      logic [1:0] retFlags;
      logic irq;
      logic irqActive;
      logic extExc;
      logic bootEnd;
   } msamc_evt_s;
   typedef struct packed {
      logic [2:0] rights;
      logic valid;
      logic [23:0] startA;
      logic [23:0] endA;
      logic [23:0] offset;
      logic [15:0] grpRd;
      logic [15:0] grpWr;
   } msamc_seg_s;
endpackage

// [hdl/msamc_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "msamc_consts.svh"
module msamc_top #(
   parameter int SEG_COUNT = 64,
   parameter bit CONTACT_ONLY = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic testStrap,
   input wire msamc_pkg::msamc_acc_s accIn,
   input wire msamc_pkg::msamc_evt_s evtIn,
   output msamc_pkg::msamc_acc_s physOut,
   output logic excReq,
   output logic [23:0] excVector,
   output logic noPush,
   output logic [1:0] modeFlags,
   output logic [15:0] grpRead,
   output logic [15:0] grpWrite
);
   localparam int IW = $clog2(SEG_COUNT);
   logic superFlag, systemFlag, irqUserReg, waitReg, lockedRd;
   msamc_pkg::msamc_mode_e superSel, mode;
   logic [15:0] vendRd, vendWr;
   logic [31:0] bankReg [3];
   logic [IW-1:0] segIdx;
   msamc_pkg::msamc_seg_s stage, hitSeg;
   msamc_pkg::msamc_seg_s segTab [SEG_COUNT];
   logic [23:0] faultAddr;
   logic s1, s2, s3, testOk;
   logic busDo, wrDo, hit, stop, rightOk, inMem, inHigh, accFault;
   logic callSys, callCfg, userEntry, sysCallBad, retBad, retOk, excNext;
   logic [23:0] phys, virt, excVecNext;
   logic [1:0] bankSel;
   logic rdAllow, wrAllow;
   logic [31:0] rdValue;

   // Mode from the two flags and the super-system selector
   always_comb begin
      if (superFlag) begin
         mode = superSel;
      end else if (systemFlag) begin
         mode = msamc_pkg::MODE_SYSTEM;
      end else begin
         mode = msamc_pkg::MODE_USER;
      end
   end

   // Strap synchroniser, accepted once the last two stages agree
   always_ff @(posedge clock) begin
      s1 <= testStrap;
      s2 <= s1;
      s3 <= s2;
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         testOk <= 1'b0;
      end else if (s2 == s3) begin
         testOk <= s3;
      end
   end

   // Segment lookup; an invalid entry ends the table
   always_comb begin
      virt = accIn.addr;
      hit = 1'b0;
      stop = 1'b0;
      hitSeg = '0;
      for (int i = 0; i < SEG_COUNT; i++) begin
         if (!stop) begin
            if (!segTab[i].valid) begin
               stop = 1'b1;
            end else if (virt >= segTab[i].startA && virt <= segTab[i].endA) begin
               hit = 1'b1;
               stop = 1'b1;
               hitSeg = segTab[i];
            end
         end
      end
      rightOk = hitSeg.rights[accIn.kind];
   end

   // Translation and physical memory checks
   always_comb begin
      if (mode == msamc_pkg::MODE_USER) begin
         phys = 24'(virt + hitSeg.offset);
      end else begin
         phys = virt;
      end
      inMem = 1'b1;
      inHigh = 1'b0;
      if (phys >= `MSAMC_ROM_BASE && phys < `MSAMC_ROM_BASE + `MSAMC_ROM_SIZE) begin
         inHigh = (phys - `MSAMC_ROM_BASE) >= (`MSAMC_ROM_SIZE >> 1);
      end else if (phys >= `MSAMC_RAM_BASE && phys < `MSAMC_RAM_BASE + `MSAMC_RAM_SIZE) begin
         inHigh = (phys - `MSAMC_RAM_BASE) >= (`MSAMC_RAM_SIZE >> 1);
      end else if (phys >= `MSAMC_EE_BASE && phys < `MSAMC_EE_BASE + `MSAMC_EE_SIZE) begin
         inHigh = (phys - `MSAMC_EE_BASE) >= (`MSAMC_EE_SIZE >> 1);
      end else begin
         inMem = 1'b0;
      end
      accFault = accIn.valid && (!inMem
         || (inHigh && mode != msamc_pkg::MODE_TEST)
         || (mode == msamc_pkg::MODE_USER && (!hit || !rightOk)));
   end

   // Call, return and exception decode
   always_comb begin
      callSys = evtIn.call && evtIn.target >= `MSAMC_SCALL_BASE
         && evtIn.target < `MSAMC_SCALL_BASE + `MSAMC_VEC_SPAN;
      callCfg = evtIn.call && evtIn.target >= `MSAMC_CCALL_BASE
         && evtIn.target < `MSAMC_CCALL_BASE + `MSAMC_VEC_SPAN;
      userEntry = evtIn.call && evtIn.target == `MSAMC_USER_ENTRY
         && mode == msamc_pkg::MODE_SYSTEM;
      sysCallBad = callSys && mode != msamc_pkg::MODE_USER;
      retBad = evtIn.ret && mode == msamc_pkg::MODE_USER
         && !(irqUserReg && evtIn.irqActive);
      retOk = evtIn.ret && !retBad;
      excNext = evtIn.extExc || retBad || sysCallBad || accFault;
      if (evtIn.extExc) begin
         excVecNext = `MSAMC_VEC_EXT;
      end else if (retBad) begin
         excVecNext = `MSAMC_VEC_RET;
      end else if (sysCallBad) begin
         excVecNext = `MSAMC_VEC_CALL;
      end else begin
         excVecNext = `MSAMC_VEC_ACCESS;
      end
   end

   // Mode flags; events win over software clears
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         superFlag <= 1'b1;
         systemFlag <= 1'b0;
         superSel <= msamc_pkg::MODE_BOOT;
      end else if (excNext) begin
         superFlag <= 1'b0;
         systemFlag <= 1'b1;
         if (superSel == msamc_pkg::MODE_BOOT) begin
            superSel <= msamc_pkg::MODE_VENDOR;
         end
      end else if (evtIn.bootEnd && mode == msamc_pkg::MODE_BOOT) begin
         if (testOk) begin
            superSel <= msamc_pkg::MODE_TEST;
         end else begin
            superFlag <= 1'b0;
            systemFlag <= 1'b1;
            superSel <= msamc_pkg::MODE_VENDOR;
         end
      end else if (retOk) begin
         {superFlag, systemFlag} <= evtIn.retFlags;
      end else if (callSys) begin
         systemFlag <= 1'b1;
      end else if (callCfg && !CONTACT_ONLY) begin
         superFlag <= 1'b1;
         if (superSel != msamc_pkg::MODE_TEST) begin
            superSel <= msamc_pkg::MODE_VENDOR;
         end
      end else if (userEntry) begin
         systemFlag <= 1'b0;
      end else if (evtIn.irq && !irqUserReg) begin
         systemFlag <= 1'b1;
      end else if (wrDo && address == `MSAMC_REG_MODE) begin
         superFlag <= superFlag & writedata[`MSAMC_BIT_SUPER];
         systemFlag <= systemFlag & writedata[`MSAMC_BIT_SYS];
         if (superSel == msamc_pkg::MODE_TEST && !writedata[`MSAMC_BIT_SUPER]) begin
            superSel <= msamc_pkg::MODE_VENDOR;
         end
      end
   end

   // Translated access and exception outputs
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         physOut <= '0;
         excReq <= 1'b0;
         excVector <= '0;
         noPush <= 1'b0;
         faultAddr <= '0;
      end else begin
         physOut.valid <= accIn.valid && !accFault;
         physOut.addr <= phys;
         physOut.kind <= accIn.kind;
         excReq <= excNext;
         excVector <= excVecNext;
         noPush <= userEntry && !excNext;
         if (accFault) begin
            faultAddr <= virt;
         end
      end
   end

   // Group rights for the register checker
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         grpRead <= '0;
         grpWrite <= '0;
      end else if (mode == msamc_pkg::MODE_USER) begin
         if (accIn.valid && accIn.kind == msamc_pkg::KIND_FETCH && hit) begin
            grpRead <= hitSeg.grpRd;
            grpWrite <= hitSeg.grpWr;
         end
      end else if (mode == msamc_pkg::MODE_VENDOR) begin
         grpRead <= vendRd;
         grpWrite <= vendWr;
      end else begin
         grpRead <= 16'hffff;
         grpWrite <= 16'hffff;
      end
   end
   assign modeFlags = {superFlag, systemFlag};

   // Bus handshake: one wait cycle per request
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         waitReg <= 1'b1;
      end else begin
         waitReg <= !((read || write) && waitReg);
      end
   end
   assign waitrequest = waitReg;
   assign busDo = (read || write) && !waitReg;

   // Fixed rights of the block's own registers
   always_comb begin
      rdAllow = 1'b1;
      wrAllow = 1'b1;
      if (address == `MSAMC_REG_CTRL) begin
         wrAllow = mode == msamc_pkg::MODE_SYSTEM;
      end else if (address == `MSAMC_REG_VRD || address == `MSAMC_REG_VWR) begin
         wrAllow = mode != msamc_pkg::MODE_VENDOR && mode != msamc_pkg::MODE_USER;
         rdAllow = mode != msamc_pkg::MODE_USER;
      end else if (address >= `MSAMC_REG_SIDX && address <= `MSAMC_REG_SATTR) begin
         wrAllow = mode == msamc_pkg::MODE_SYSTEM;
         rdAllow = mode != msamc_pkg::MODE_USER;
      end else if (address == `MSAMC_REG_FAULT) begin
         wrAllow = 1'b0;
      end
      wrDo = busDo && write && wrAllow;
   end

   // Banked copy selected by mode
   always_comb begin
      if (superFlag) begin
         bankSel = 2'd2;
      end else if (systemFlag) begin
         bankSel = 2'd1;
      end else begin
         bankSel = 2'd0;
      end
   end

   // Read value decode
   always_comb begin
      if (!rdAllow) begin
         rdValue = `MSAMC_FIXED_RD;
      end else if (address == `MSAMC_REG_MODE) begin
         rdValue = {27'h0, mode, superFlag, systemFlag};
      end else if (address == `MSAMC_REG_CTRL) begin
         rdValue = {31'h0, irqUserReg};
      end else if (address == `MSAMC_REG_VRD) begin
         rdValue = {16'h0, vendRd};
      end else if (address == `MSAMC_REG_VWR) begin
         rdValue = {16'h0, vendWr};
      end else if (address == `MSAMC_REG_SIDX) begin
         rdValue = 32'(segIdx);
      end else if (address == `MSAMC_REG_SSTART) begin
         rdValue = {8'h0, stage.startA};
      end else if (address == `MSAMC_REG_SEND) begin
         rdValue = {8'h0, stage.endA};
      end else if (address == `MSAMC_REG_SOFS) begin
         rdValue = {8'h0, stage.offset};
      end else if (address == `MSAMC_REG_SGRP) begin
         rdValue = {stage.grpWr, stage.grpRd};
      end else if (address == `MSAMC_REG_SATTR) begin
         rdValue = {28'h0, stage.valid, stage.rights};
      end else if (address == `MSAMC_REG_BANK) begin
         rdValue = bankReg[bankSel];
      end else if (address == `MSAMC_REG_FAULT) begin
         rdValue = {8'h0, faultAddr};
      end else begin
         rdValue = 32'h0;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         readdata <= '0;
      end else if (read && waitReg) begin
         readdata <= rdValue;
      end
   end

   // Control and vendor group registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqUserReg <= 1'b0;
         vendRd <= '0;
         vendWr <= '0;
         bankReg <= '{default: '0};
      end else if (wrDo) begin
         if (address == `MSAMC_REG_CTRL) begin
            irqUserReg <= writedata[0];
         end else if (address == `MSAMC_REG_VRD) begin
            vendRd <= writedata[15:0];
         end else if (address == `MSAMC_REG_VWR) begin
            vendWr <= writedata[15:0];
         end else if (address == `MSAMC_REG_BANK) begin
            bankReg[bankSel] <= writedata;
         end
      end
   end

   // Segment staging; the attribute write commits the entry
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         segIdx <= '0;
         stage <= '0;
         segTab <= '{default: '0};
      end else if (wrDo) begin
         if (address == `MSAMC_REG_SIDX) begin
            segIdx <= writedata[IW-1:0];
         end else if (address == `MSAMC_REG_SSTART) begin
            stage.startA <= writedata[23:0];
         end else if (address == `MSAMC_REG_SEND) begin
            stage.endA <= writedata[23:0];
         end else if (address == `MSAMC_REG_SOFS) begin
            stage.offset <= writedata[23:0];
         end else if (address == `MSAMC_REG_SGRP) begin
            stage.grpRd <= writedata[15:0];
            stage.grpWr <= writedata[31:16];
         end else if (address == `MSAMC_REG_SATTR) begin
            stage.rights <= writedata[2:0];
            stage.valid <= writedata[3];
            segTab[segIdx] <= {writedata[2:0], writedata[3], stage.startA, stage.endA,
               stage.offset, stage.grpRd, stage.grpWr};
         end
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence sSysEntry;
      ##1 systemFlag && !superFlag;
   endsequence
   sequence sExcTo(logic [23:0] v);
      ##1 excReq && excVector == v;
   endsequence
   a_reset_boot: assert property ($past(!rst_n) |-> mode == msamc_pkg::MODE_BOOT)
      else $error("Reset did not enter boot mode");
   a_scall_enter: assert property (callSys && mode == msamc_pkg::MODE_USER && !excNext
         && !(evtIn.ret) |-> sSysEntry)
      else $error("System call did not enter system mode");
   a_scall_illegal: assert property (sysCallBad && !evtIn.extExc && !retBad
         |-> sExcTo(`MSAMC_VEC_CALL))
      else $error("Illegal system call not trapped");
   a_exc_sysflag: assert property (excNext |-> sSysEntry)
      else $error("Exception did not set system flag");
   a_out_of_mem: assert property (accIn.valid && !inMem |=> excReq && !physOut.valid)
      else $error("Access outside memory not trapped");
   a_user_entry: assert property (userEntry && !excNext |=> mode == msamc_pkg::MODE_USER
         && noPush)
      else $error("User entry call misbehaved");
   a_clear_only: assert property (!$past(excNext || evtIn.call || evtIn.ret || evtIn.irq
         || evtIn.bootEnd) |-> !$rose(systemFlag) && !$rose(superFlag))
      else $error("Mode flag set by a write");
   a_full_groups: assert property (mode == msamc_pkg::MODE_SYSTEM |=> grpRead == 16'hffff
         && grpWrite == 16'hffff)
      else $error("System mode lacks full group rights");
   a_vendor_lock: assert property (mode == msamc_pkg::MODE_VENDOR |=> $stable(vendRd)
         && $stable(vendWr))
      else $error("Vendor group register changed in vendor mode");
   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("Bus request not answered in one cycle");
endmodule
`default_nettype wire

// [verif/msamc_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
// CPU core stand-in: one-cycle accesses and one-cycle mode events
module msamc_cpu_model (
   input wire logic clock,
   input wire logic [1:0] modeFlags,
   output var msamc_pkg::msamc_acc_s accIn,
   output var msamc_pkg::msamc_evt_s evtIn
);
   logic [1:0] flagStack[$];
   logic irqLive;
   // Idle lines at time zero
   initial begin
      accIn = '0;
      evtIn = '0;
      irqLive = 1'h0;
   end
   // One access; the address turns over once released
   task automatic access(input logic [23:0] va, input logic [1:0] k);
      @(posedge clock);
      accIn <= '{valid: 1'h1, addr: va, kind: msamc_pkg::msamc_kind_e'(k)};
      @(posedge clock);
      accIn <= '{valid: 1'h0, addr: ~va, kind: msamc_pkg::msamc_kind_e'(k)};
      #1;
   endtask
   // One event; interrupt-active level follows the model state
   task automatic fire(input msamc_pkg::msamc_evt_s e, input logic liveAfter);
      @(posedge clock);
      e.irqActive = irqLive;
      evtIn <= e;
      irqLive = liveAfter;
      @(posedge clock);
      evtIn <= '{target: ~e.target, irqActive: irqLive, default: '0};
      #1;
   endtask
   // Call; user entry pushes nothing
   task automatic call(input logic [23:0] t);
      msamc_pkg::msamc_evt_s e;
      e = '0;
      e.call = 1'h1;
      e.target = t;
      if (t != 24'h800000) flagStack.push_back(modeFlags);
      fire(e, irqLive);
   endtask
   // Interrupt entry saves the flags
   task automatic irq();
      msamc_pkg::msamc_evt_s e;
      e = '0;
      e.irq = 1'h1;
      flagStack.push_back(modeFlags);
      fire(e, 1'h1);
   endtask
   // Return hands back the saved flags
   task automatic irqReturn();
      msamc_pkg::msamc_evt_s e;
      e = '0;
      e.ret = 1'h1;
      e.retFlags = (flagStack.size() > 0) ? flagStack.pop_back() : modeFlags;
      fire(e, 1'h0);
   endtask
   // Other exception source or end of boot
   task automatic other(input logic ext, input logic boot);
      msamc_pkg::msamc_evt_s e;
      e = '0;
      e.extExc = ext;
      e.bootEnd = boot;
      fire(e, irqLive);
   endtask
endmodule
`default_nettype wire

// [verif/msamc_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "msamc_consts.svh"
module msamc_top_tb;
   typedef struct packed {
      logic user;
      logic [23:0] va;
      logic [1:0] kind;
      logic ok;
      logic [23:0] pa;
   } msamc_row_s;
   logic clock, rst_n, read, write, waitrequest, testStrap, excReq, noPush;
   logic [5:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [23:0] excVector;
   logic [1:0] modeFlags;
   logic [1:0] modeFlagsCo;
   logic [15:0] grpRead, grpWrite;
   msamc_pkg::msamc_acc_s accIn, physOut;
   msamc_pkg::msamc_evt_s evtIn;
   int fail_count, compares;
   msamc_row_s rows[12];
   logic [31:0] segTab[3][5];
   logic [5:0] segReg[5];
   msamc_top #(.SEG_COUNT(4), .CONTACT_ONLY(1'h0)) dut (
      .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .testStrap(testStrap), .accIn(accIn), .evtIn(evtIn), .physOut(physOut),
      .excReq(excReq), .excVector(excVector), .noPush(noPush), .modeFlags(modeFlags),
      .grpRead(grpRead), .grpWrite(grpWrite));
   msamc_cpu_model cpu (.clock(clock), .modeFlags(modeFlags), .accIn(accIn), .evtIn(evtIn));
   // Contact-only build on the same stimulus; only its mode flags are watched
   msamc_top #(.SEG_COUNT(4), .CONTACT_ONLY(1'h1)) dutCo (
      .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(), .waitrequest(), .testStrap(testStrap),
      .accIn(accIn), .evtIn(evtIn), .physOut(), .excReq(), .excVector(), .noPush(),
      .modeFlags(modeFlagsCo), .grpRead(), .grpWrite());
   // Clock
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   // Verdict and end of run
   task automatic results();
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #100000;
      fail_count++;
      results();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus cycle held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'h0);
      chk({31'h0, waitrequest}, 32'h0);
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
      #1;
   endtask
   task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Exception outputs and mode flags after an event
   task automatic excChk(input logic x, input logic [23:0] v, input logic [1:0] f);
      chk({31'h0, excReq}, {31'h0, x});
      if (x) chk({8'h0, excVector}, {8'h0, v});
      chk({30'h0, modeFlags}, {30'h0, f});
   endtask
   task automatic enterUser();
      cpu.call(24'h800000);
      chk({31'h0, noPush}, 32'h1);
      excChk(1'h0, 24'h0, 2'h0);
   endtask
   task automatic doReset(input logic strap);
      @(posedge clock);
      rst_n <= 1'h0;
      testStrap <= strap;
      repeat (2) @(posedge clock);
      rst_n <= 1'h1;
      repeat (3) @(posedge clock);
      #1;
      chk({30'h0, modeFlags}, 32'h2);
      chk({grpWrite, grpRead}, 32'hffff_ffff);
   endtask
   // Main sequence
   initial begin
      rst_n = 1'h0;
      read = 1'h0;
      write = 1'h0;
      address = 6'h0;
      writedata = 32'h0;
      testStrap = 1'h0;
      fail_count = 0;
      compares = 0;
      segTab = '{'{32'h800000, 32'h8000ff, 32'h800100, 32'h00ff0f0f, 32'hd},
                 '{32'h900000, 32'h9000ff, 32'h800000, 32'h0000ffff, 32'hb},
                 '{32'ha00000, 32'ha000ff, 32'h620000, 32'h0, 32'h9}};
      segReg = '{`MSAMC_REG_SSTART, `MSAMC_REG_SEND, `MSAMC_REG_SOFS, `MSAMC_REG_SGRP,
                 `MSAMC_REG_SATTR};
      rows = '{'{1'h0, 24'h000100, 2'h0, 1'h1, 24'h000100},
               '{1'h0, 24'h100800, 2'h1, 1'h1, 24'h100800},
               '{1'h0, 24'h21ff00, 2'h2, 1'h1, 24'h21ff00},
               '{1'h0, 24'h300000, 2'h0, 1'h0, 24'h0},
               '{1'h0, 24'h800010, 2'h0, 1'h0, 24'h0},
               '{1'h1, 24'h800010, 2'h2, 1'h1, 24'h000110},
               '{1'h1, 24'h9000fc, 2'h0, 1'h1, 24'h1000fc},
               '{1'h1, 24'h900000, 2'h1, 1'h1, 24'h100000},
               '{1'h1, 24'h800010, 2'h1, 1'h0, 24'h0},
               '{1'h1, 24'ha00004, 2'h0, 1'h0, 24'h0},
               '{1'h1, 24'h880000, 2'h0, 1'h0, 24'h0},
               '{1'h1, 24'h900000, 2'h2, 1'h0, 24'h0}};
      doReset(1'h0);
      rdChk(`MSAMC_REG_MODE, 32'h2);
      cpu.other(1'h0, 1'h1);
      rdChk(`MSAMC_REG_MODE, 32'hd);
      // Segment table, vendor rights and banked copy set up in system mode
      for (int s = 0; s < 3; s++) begin
         bus(1'h1, `MSAMC_REG_SIDX, s);
         for (int f = 0; f < 5; f++) bus(1'h1, segReg[f], segTab[s][f]);
      end
      bus(1'h1, `MSAMC_REG_VRD, 32'h1234);
      bus(1'h1, `MSAMC_REG_VWR, 32'h5678);
      bus(1'h1, `MSAMC_REG_BANK, 32'h1111_1111);
      foreach (rows[i]) begin
         if (rows[i].user && modeFlags !== 2'h0) enterUser();
         cpu.access(rows[i].va, rows[i].kind);
         if (rows[i].ok) begin
            chk({5'h0, physOut.kind, physOut.valid, physOut.addr},
               {5'h0, rows[i].kind, 1'h1, rows[i].pa});
            chk({31'h0, excReq}, 32'h0);
         end else begin
            chk({31'h0, physOut.valid}, 32'h0);
            excChk(1'h1, `MSAMC_VEC_ACCESS, 2'h1);
         end
      end
      rdChk(`MSAMC_REG_FAULT, 32'h900000);
      enterUser();
      cpu.access(24'h800020, 2'h2);
      @(posedge clock);
      #1;
      chk({grpWrite, grpRead}, 32'h00ff_0f0f);
      bus(1'h1, `MSAMC_REG_MODE, 32'h3);
      excChk(1'h0, 24'h0, 2'h0);
      rdChk(`MSAMC_REG_SSTART, `MSAMC_FIXED_RD);
      rdChk(`MSAMC_REG_VRD, `MSAMC_FIXED_RD);
      bus(1'h1, `MSAMC_REG_BANK, 32'h2222_2222);
      rdChk(`MSAMC_REG_BANK, 32'h2222_2222);
      bus(1'h1, `MSAMC_REG_CTRL, 32'h1);
      rdChk(`MSAMC_REG_CTRL, 32'h0);
      cpu.irq();
      excChk(1'h0, 24'h0, 2'h1);
      cpu.irqReturn();
      excChk(1'h0, 24'h0, 2'h0);
      cpu.irqReturn();
      excChk(1'h1, `MSAMC_VEC_RET, 2'h1);
      rdChk(`MSAMC_REG_BANK, 32'h1111_1111);
      cpu.call(`MSAMC_SCALL_BASE);
      excChk(1'h1, `MSAMC_VEC_CALL, 2'h1);
      bus(1'h1, `MSAMC_REG_CTRL, 32'h1);
      enterUser();
      cpu.irq();
      excChk(1'h0, 24'h0, 2'h0);
      cpu.irqReturn();
      excChk(1'h0, 24'h0, 2'h0);
      cpu.call(24'h00ff40);
      excChk(1'h0, 24'h0, 2'h1);
      cpu.irqReturn();
      excChk(1'h0, 24'h0, 2'h0);
      cpu.other(1'h1, 1'h0);
      excChk(1'h1, `MSAMC_VEC_EXT, 2'h1);
      bus(1'h1, `MSAMC_REG_MODE, 32'h0);
      excChk(1'h0, 24'h0, 2'h0);
      cpu.call(`MSAMC_SCALL_BASE);
      excChk(1'h0, 24'h0, 2'h1);
      cpu.call(`MSAMC_CCALL_BASE);
      excChk(1'h0, 24'h0, 2'h3);
      chk({30'h0, modeFlagsCo}, 32'h1);
      rdChk(`MSAMC_REG_MODE, 32'hb);
      chk({grpWrite, grpRead}, 32'h5678_1234);
      bus(1'h1, `MSAMC_REG_VRD, 32'h0);
      rdChk(`MSAMC_REG_VRD, 32'h1234);
      bus(1'h1, `MSAMC_REG_BANK, 32'h3333_3333);
      rdChk(`MSAMC_REG_BANK, 32'h3333_3333);
      cpu.irqReturn();
      excChk(1'h0, 24'h0, 2'h1);
      rdChk(`MSAMC_REG_BANK, 32'h1111_1111);
      rdChk(6'h3c, 32'h0);
      // Test mode reaches the reserved partition
      doReset(1'h1);
      cpu.other(1'h0, 1'h1);
      rdChk(`MSAMC_REG_MODE, 32'h6);
      cpu.access(24'h020000, 2'h0);
      chk({7'h0, physOut.valid, physOut.addr}, 32'h0102_0000);
      results();
   end
endmodule
`default_nettype wire
